// >>> hdl/idd_pkg.sv
// Package: identify-drive word map, geometry table and timing constants
package idd_pkg;
	// Word indices inside the 256-word identify block
	localparam logic [7:0] IDD_W_CONFIG = 8'h00, IDD_W_DEF_CYL = 8'h01, IDD_W_DEF_HEAD = 8'h03;
	localparam logic [7:0] IDD_W_TRK_BYTES = 8'h04, IDD_W_SEC_BYTES = 8'h05, IDD_W_DEF_SPT = 8'h06;
	localparam logic [7:0] IDD_W_DEV_MSW = 8'h07, IDD_W_DEV_LSW = 8'h08;
	localparam logic [7:0] IDD_W_SER_FIRST = 8'h0A, IDD_W_SER_LAST = 8'h13;
	localparam logic [7:0] IDD_W_BUF_TYPE = 8'h14, IDD_W_BUF_SIZE = 8'h15, IDD_W_ECC = 8'h16;
	localparam logic [7:0] IDD_W_FW_FIRST = 8'h17, IDD_W_FW_LAST = 8'h1A;
	localparam logic [7:0] IDD_W_MDL_FIRST = 8'h1B, IDD_W_MDL_LAST = 8'h2E;
	localparam logic [7:0] IDD_W_MULTI = 8'h2F, IDD_W_CAPS = 8'h31, IDD_W_PIO = 8'h33;
	localparam logic [7:0] IDD_W_VALID = 8'h35, IDD_W_CUR_CYL = 8'h36, IDD_W_CUR_HEAD = 8'h37;
	localparam logic [7:0] IDD_W_CUR_SPT = 8'h38, IDD_W_CUR_LSW = 8'h39, IDD_W_CUR_MSW = 8'h3A;
	localparam logic [7:0] IDD_W_MSET = 8'h3B, IDD_W_LBA_LSW = 8'h3C, IDD_W_LBA_MSW = 8'h3D;
	localparam logic [7:0] IDD_W_DMA = 8'h3F, IDD_W_APIO = 8'h40;
	localparam logic [7:0] IDD_W_CYC_FIRST = 8'h41, IDD_W_CYC_LAST = 8'h44;
	localparam logic [7:0] IDD_W_LAST = 8'hFF;
	// Fixed word values
	localparam logic [15:0] IDD_V_CFG_CARD = 16'h848A, IDD_V_CFG_IDE = 16'h044A;
	localparam logic [15:0] IDD_V_SEC_BYTES = 16'h0240, IDD_V_BUF_TYPE = 16'h0002;
	localparam logic [15:0] IDD_V_BUF_SIZE = 16'h0002, IDD_V_ECC = 16'h0004;
	localparam logic [15:0] IDD_V_MULTI = 16'h0001, IDD_V_CAPS = 16'h0300, IDD_V_PIO = 16'h0203;
	localparam logic [15:0] IDD_V_VALID = 16'h0003, IDD_V_MSET = 16'h0100;
	localparam logic [15:0] IDD_V_DMA = 16'h0407, IDD_V_APIO = 16'h0003, IDD_V_CYC = 16'h0078;
	// Capacity codes
	localparam logic [2:0] IDD_CAP_256M = 3'h0, IDD_CAP_512M = 3'h1, IDD_CAP_1G = 3'h2;
	localparam logic [2:0] IDD_CAP_2G = 3'h3, IDD_CAP_4G = 3'h4, IDD_CAP_8G = 3'h5;
	// Geometry
	localparam logic [15:0] IDD_HEADS = 16'h0010, IDD_SPT_SMALL = 16'h0020, IDD_SPT_LARGE = 16'h003F;
	localparam logic [15:0] IDD_CYL_256M = 16'h03D4, IDD_CYL_512M = 16'h03E1, IDD_CYL_1G = 16'h07C2;
	localparam logic [15:0] IDD_CYL_2G = 16'h0F82, IDD_CYL_4G = 16'h1F04, IDD_CYL_8G = 16'h3E08;
	// Command-to-data-request latency
	localparam int IDD_CLK_HZ = 50_000_000;
	localparam int IDD_DRQ_TYP_MS = 1;
	localparam int IDD_DRQ_MAX_MS = 5;
	localparam int IDD_DRQ_TYP_CYC = IDD_DRQ_TYP_MS * (IDD_CLK_HZ / 1000);
	localparam int IDD_DRQ_MAX_CYC = IDD_DRQ_MAX_MS * (IDD_CLK_HZ / 1000);
	localparam logic [15:0] IDD_SPACE2 = 16'h2020;

	typedef struct packed {
		logic [15:0] cyl;
		logic [15:0] heads;
		logic [15:0] spt;
	} idd_geom_t;

	typedef struct packed {
		logic [159:0] serial;
		logic [63:0] firmware;
		logic [319:0] model;
		logic model_override;
	} idd_ident_t;

	typedef enum logic [2:0] {
		IDD_ST_IDLE = 3'b001,
		IDD_ST_PREP = 3'b010,
		IDD_ST_XFER = 3'b100
	} idd_state_t;
endpackage

// >>> hdl/idd_gen.sv
// Identify-drive data block generator on the task-file data port
//
// Contract
// RULE_01: Word 0 reads 848A in card modes, 044A in True IDE mode.
// RULE_02: Word 5 reads 0240; word 4 reads zero.
// RULE_03: Words 7 and 8 hold sector count, high half first.
// RULE_04: Words 57 and 58 hold current capacity, low half first.
// RULE_05: Word 49 reads 0300: DMA bit 8, LBA bit 9.
// RULE_06: Word 47 reads 0001, one sector per multiple block.
// RULE_07: Word 20 buffer type 0002, word 21 buffer size 0002.
// RULE_08: Word 22 reads 0004 ECC bytes for long commands.
// RULE_09: Words 10 to 19 carry a 20-byte ASCII serial number.
// RULE_10: Words 23 to 26 carry firmware revision, first character high.
// RULE_11: Words 27 to 46 carry model string, capacity plus card type, overridable.
// RULE_12: Word 51 reads 0203.
// RULE_13: Word 53 reads 0003.
// RULE_14: Word 63 reads 0407.
// RULE_15: Word 64 reads 0003.
// RULE_16: Words 65 to 68 each read 0078.
// RULE_17: Geometry by capacity: 16 heads; 32 or 63 sectors; listed cylinders.
// RULE_18: Words 1, 3, 6 hold default cylinders, heads, sectors per track.
// RULE_19: Words 54, 55, 56 hold current cylinders, heads, sectors.
// RULE_20: Words 60 and 61 hold total LBA sector count.
// RULE_21: Data request rises within 5 ms of command, typically 1 ms.
// RULE_22: Words 69 through 255 read zero.
// RULE_23: 256 words delivered in ascending order; host reads all.
`timescale 1ns/1ps
module idd_gen #(
	parameter int DRQ_DELAY_CYC = idd_pkg::IDD_DRQ_TYP_CYC,
	parameter int DRQ_MAX_CYC = idd_pkg::IDD_DRQ_MAX_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Card configuration
	input wire logic true_ide,
	input wire logic [2:0] capacity_sel,
	input wire idd_pkg::idd_ident_t ident,
	// Command and data port
	input wire logic identify_start,
	input wire logic data_rd,
	output logic drq,
	output logic busy,
	output logic [15:0] data_out
);
	import idd_pkg::*;

	idd_state_t state_reg, state_next;
	logic [31:0] prep_cnt_reg, prep_cnt_next;
	logic [7:0] idx_reg, idx_next;
	logic [15:0] data_reg, data_next;
	logic ide_reg, ide_next;
	logic [2:0] cap_reg, cap_next;
	idd_geom_t geom;
	logic [31:0] lba;
	logic [319:0] model_str;
	logic [15:0] word_now;

	function automatic idd_geom_t geom_of(input logic [2:0] cap);
		idd_geom_t g;
		g.heads = IDD_HEADS; // RULE_17
		g.spt = IDD_SPT_LARGE;
		case (cap)
			IDD_CAP_512M: g.cyl = IDD_CYL_512M;
			IDD_CAP_1G: g.cyl = IDD_CYL_1G;
			IDD_CAP_2G: g.cyl = IDD_CYL_2G;
			IDD_CAP_4G: g.cyl = IDD_CYL_4G;
			IDD_CAP_8G: g.cyl = IDD_CYL_8G;
			default: begin
				g.cyl = IDD_CYL_256M;
				g.spt = IDD_SPT_SMALL;
			end
		endcase
		return g;
	endfunction

	function automatic logic [319:0] model_of(input logic [2:0] cap);
		logic [319:0] m;
		case (cap)
			IDD_CAP_512M: m = {"512MB PCMCIA card", {23{8'h20}}};
			IDD_CAP_1G: m = {"1GB PCMCIA card", {25{8'h20}}};
			IDD_CAP_2G: m = {"2GB PCMCIA card", {25{8'h20}}};
			IDD_CAP_4G: m = {"4GB PCMCIA card", {25{8'h20}}};
			IDD_CAP_8G: m = {"8GB PCMCIA card", {25{8'h20}}};
			default: m = {"256MB PCMCIA card", {23{8'h20}}};
		endcase
		return m;
	endfunction

	// First character of a pair sits in the high byte
	function automatic logic [15:0] str_word(input logic [319:0] s, input logic [7:0] k);
		logic [319:0] sh;
		sh = s << (16 * int'(k));
		return sh[319:304];
	endfunction

	function automatic logic [15:0] word_of(input logic [7:0] i, input logic ide,
			input idd_geom_t g, input logic [31:0] n, input logic [319:0] mdl,
			input idd_ident_t id);
		logic [15:0] w;
		w = 16'h0000;
		case (i)
			IDD_W_CONFIG: w = ide ? IDD_V_CFG_IDE : IDD_V_CFG_CARD; // RULE_01
			IDD_W_DEF_CYL: w = g.cyl; // RULE_18
			IDD_W_DEF_HEAD: w = g.heads; // RULE_18
			IDD_W_TRK_BYTES: w = 16'h0000; // RULE_02
			IDD_W_SEC_BYTES: w = IDD_V_SEC_BYTES; // RULE_02
			IDD_W_DEF_SPT: w = g.spt; // RULE_18
			IDD_W_DEV_MSW: w = n[31:16]; // RULE_03
			IDD_W_DEV_LSW: w = n[15:0]; // RULE_03
			IDD_W_BUF_TYPE: w = IDD_V_BUF_TYPE; // RULE_07
			IDD_W_BUF_SIZE: w = IDD_V_BUF_SIZE; // RULE_07
			IDD_W_ECC: w = IDD_V_ECC; // RULE_08
			IDD_W_MULTI: w = IDD_V_MULTI; // RULE_06
			IDD_W_CAPS: w = IDD_V_CAPS; // RULE_05
			IDD_W_PIO: w = IDD_V_PIO; // RULE_12
			IDD_W_VALID: w = IDD_V_VALID; // RULE_13
			IDD_W_CUR_CYL: w = g.cyl; // RULE_19
			IDD_W_CUR_HEAD: w = g.heads; // RULE_19
			IDD_W_CUR_SPT: w = g.spt; // RULE_19
			IDD_W_CUR_LSW: w = n[15:0]; // RULE_04
			IDD_W_CUR_MSW: w = n[31:16]; // RULE_04
			IDD_W_MSET: w = IDD_V_MSET;
			IDD_W_LBA_LSW: w = n[15:0]; // RULE_20
			IDD_W_LBA_MSW: w = n[31:16]; // RULE_20
			IDD_W_DMA: w = IDD_V_DMA; // RULE_14
			IDD_W_APIO: w = IDD_V_APIO; // RULE_15
			default: begin
				if (i >= IDD_W_SER_FIRST && i <= IDD_W_SER_LAST) begin
					w = str_word({id.serial, 160'h0}, i - IDD_W_SER_FIRST); // RULE_09
				end else if (i >= IDD_W_FW_FIRST && i <= IDD_W_FW_LAST) begin
					w = str_word({id.firmware, 256'h0}, i - IDD_W_FW_FIRST); // RULE_10
				end else if (i >= IDD_W_MDL_FIRST && i <= IDD_W_MDL_LAST) begin
					w = str_word(mdl, i - IDD_W_MDL_FIRST); // RULE_11
				end else if (i >= IDD_W_CYC_FIRST && i <= IDD_W_CYC_LAST) begin
					w = IDD_V_CYC; // RULE_16
				end else begin
					w = 16'h0000; // RULE_22
				end
			end
		endcase
		return w;
	endfunction

	always_comb begin
		geom = geom_of(cap_reg);
		lba = 32'(geom.cyl) * 32'(geom.heads) * 32'(geom.spt); // RULE_20
		model_str = ident.model_override ? ident.model : model_of(cap_reg); // RULE_11
		word_now = word_of(idx_next, ide_reg, geom, lba, model_str, ident);
	end

	// Sequencer: latch mode and capacity, wait, then stream 256 words
	always_comb begin
		state_next = state_reg;
		prep_cnt_next = prep_cnt_reg;
		idx_next = idx_reg;
		ide_next = ide_reg;
		cap_next = cap_reg;
		case (state_reg)
			IDD_ST_IDLE: begin
				if (identify_start) begin
					state_next = IDD_ST_PREP;
					prep_cnt_next = 32'h0000_0000;
					ide_next = true_ide;
					cap_next = capacity_sel;
				end
			end
			IDD_ST_PREP: begin
				prep_cnt_next = prep_cnt_reg + 32'h0000_0001;
				if (prep_cnt_reg >= 32'(DRQ_DELAY_CYC - 1)) begin
					state_next = IDD_ST_XFER; // RULE_21
					idx_next = 8'h00;
				end
			end
			IDD_ST_XFER: begin
				if (data_rd) begin
					if (idx_reg == IDD_W_LAST) begin
						state_next = IDD_ST_IDLE; // RULE_23
					end else begin
						idx_next = idx_reg + 8'h01; // RULE_23
					end
				end
			end
			default: state_next = IDD_ST_IDLE;
		endcase
	end

	always_comb begin
		data_next = data_reg;
		if (state_next == IDD_ST_XFER) begin
			data_next = word_now;
		end else if (state_next == IDD_ST_IDLE) begin
			data_next = 16'h0000;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_reg <= IDD_ST_IDLE;
			prep_cnt_reg <= 32'h0000_0000;
			idx_reg <= 8'h00;
			data_reg <= 16'h0000;
			ide_reg <= 1'b0;
			cap_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			prep_cnt_reg <= prep_cnt_next;
			idx_reg <= idx_next;
			data_reg <= data_next;
			ide_reg <= ide_next;
			cap_reg <= cap_next;
		end
	end

	assign drq = (state_reg == IDD_ST_XFER);
	assign busy = (state_reg == IDD_ST_PREP);
	assign data_out = data_reg;

	// Checks
	logic [31:0] wait_cnt_reg, wait_cnt_next;
	always_comb begin
		wait_cnt_next = 32'h0000_0000;
		if (state_reg == IDD_ST_PREP) begin
			wait_cnt_next = wait_cnt_reg + 32'h0000_0001;
		end
	end
	always_ff @(posedge clock) begin
		if (!resetn) begin
			wait_cnt_reg <= 32'h0000_0000;
		end else begin
			wait_cnt_reg <= wait_cnt_next;
		end
	end

	sequence s_last_read;
		drq && idx_reg == IDD_W_LAST && data_rd;
	endsequence

	sequence s_back_idle;
		!drq && data_out == 16'h0000;
	endsequence

	a_drq_latency: assert property (@(posedge clock) disable iff (!resetn) // RULE_21
		wait_cnt_reg < 32'(DRQ_MAX_CYC)) else $error("data request later than max latency");
	a_cfg_word: assert property (@(posedge clock) disable iff (!resetn) // RULE_01
		drq && idx_reg == IDD_W_CONFIG |-> data_out == (ide_reg ? 16'h044A : 16'h848A))
		else $error("config word wrong for mode");
	a_sec_bytes: assert property (@(posedge clock) disable iff (!resetn) // RULE_02
		drq && idx_reg == IDD_W_SEC_BYTES |-> data_out == 16'h0240)
		else $error("bytes per sector word wrong");
	a_dev_order: assert property (@(posedge clock) disable iff (!resetn) // RULE_03
		drq && idx_reg == IDD_W_DEV_MSW && data_rd |=> data_out == lba[15:0]
		&& $past(data_out) == lba[31:16]) else $error("device sector count order wrong");
	a_cur_order: assert property (@(posedge clock) disable iff (!resetn) // RULE_04
		drq && idx_reg == IDD_W_CUR_LSW && data_rd |=> data_out == lba[31:16]
		&& $past(data_out) == lba[15:0]) else $error("current capacity order wrong");
	a_caps_word: assert property (@(posedge clock) disable iff (!resetn) // RULE_05
		drq && idx_reg == IDD_W_CAPS |-> data_out == 16'h0300)
		else $error("capabilities word wrong");
	a_cycle_words: assert property (@(posedge clock) disable iff (!resetn) // RULE_16
		drq && idx_reg >= IDD_W_CYC_FIRST && idx_reg <= IDD_W_CYC_LAST |-> data_out == 16'h0078)
		else $error("cycle time word wrong");
	a_reserved_zero: assert property (@(posedge clock) disable iff (!resetn) // RULE_22
		drq && idx_reg > IDD_W_CYC_LAST |-> data_out == 16'h0000)
		else $error("reserved word not zero");
	a_word_order: assert property (@(posedge clock) disable iff (!resetn) // RULE_23
		drq && data_rd && idx_reg != IDD_W_LAST |=> drq && idx_reg == $past(idx_reg) + 8'h01)
		else $error("words not in ascending order");
	a_block_end: assert property (@(posedge clock) disable iff (!resetn) // RULE_23
		s_last_read |=> s_back_idle) else $error("block did not end after last word");
	a_geom_8g: assert property (@(posedge clock) disable iff (!resetn) // RULE_17
		drq && cap_reg == IDD_CAP_8G && idx_reg == IDD_W_LBA_LSW |-> data_out == 16'h3F80)
		else $error("8G total sector count wrong");
	a_trk_bytes: assert property (@(posedge clock) disable iff (!resetn) // RULE_02
		drq && idx_reg == IDD_W_TRK_BYTES |-> data_out == 16'h0000)
		else $error("bytes per track word not zero");
	a_multi_word: assert property (@(posedge clock) disable iff (!resetn) // RULE_06
		drq && idx_reg == IDD_W_MULTI |-> data_out == 16'h0001)
		else $error("multiple sector limit word wrong");
	a_buf_words: assert property (@(posedge clock) disable iff (!resetn) // RULE_07
		drq && (idx_reg == IDD_W_BUF_TYPE || idx_reg == IDD_W_BUF_SIZE) |-> data_out == 16'h0002)
		else $error("buffer word wrong");
	a_ecc_word: assert property (@(posedge clock) disable iff (!resetn) // RULE_08
		drq && idx_reg == IDD_W_ECC |-> data_out == 16'h0004)
		else $error("long command byte count word wrong");
	a_pio_word: assert property (@(posedge clock) disable iff (!resetn) // RULE_12
		drq && idx_reg == IDD_W_PIO |-> data_out == 16'h0203)
		else $error("transfer timing mode word wrong");
	a_valid_word: assert property (@(posedge clock) disable iff (!resetn) // RULE_13
		drq && idx_reg == IDD_W_VALID |-> data_out == 16'h0003)
		else $error("translation valid word wrong");
	a_dma_word: assert property (@(posedge clock) disable iff (!resetn) // RULE_14
		drq && idx_reg == IDD_W_DMA |-> data_out == 16'h0407)
		else $error("multiword transfer modes word wrong");
	a_apio_word: assert property (@(posedge clock) disable iff (!resetn) // RULE_15
		drq && idx_reg == IDD_W_APIO |-> data_out == 16'h0003)
		else $error("advanced transfer modes word wrong");
	a_head_words: assert property (@(posedge clock) disable iff (!resetn) // RULE_18
		drq && (idx_reg == IDD_W_DEF_HEAD || idx_reg == IDD_W_CUR_HEAD) |-> data_out == 16'h0010)
		else $error("head count word wrong");
	a_spt_256m: assert property (@(posedge clock) disable iff (!resetn) // RULE_17
		drq && cap_reg == IDD_CAP_256M && (idx_reg == IDD_W_DEF_SPT || idx_reg == IDD_W_CUR_SPT)
		|-> data_out == 16'h0020)
		else $error("256M sectors per track wrong");
	a_geom_256m: assert property (@(posedge clock) disable iff (!resetn) // RULE_19
		drq && cap_reg == IDD_CAP_256M && (idx_reg == IDD_W_DEF_CYL || idx_reg == IDD_W_CUR_CYL)
		|-> data_out == 16'h03D4)
		else $error("256M cylinder count wrong");
	a_lba_256m: assert property (@(posedge clock) disable iff (!resetn) // RULE_20
		drq && cap_reg == IDD_CAP_256M && idx_reg == IDD_W_LBA_LSW |-> data_out == 16'hA800)
		else $error("256M total sector count wrong");
endmodule

// >>> verif/idd_host.sv
// Host model that starts an identify command and reads the data block
`timescale 1ns/1ps
module idd_host (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Bench control
	input wire logic go,
	input wire logic stall,
	// Device side
	input wire logic drq,
	output logic identify_start,
	output logic data_rd
);
	int n_reg;
	int n_next;
	always_comb n_next = n_reg + int'(data_rd && drq);
	always @(posedge clock) begin
		if (!resetn) begin
			n_reg <= 0;
			identify_start <= 1'b0;
			data_rd <= 1'b0;
		end else begin
			identify_start <= go;
			// Stop after the last word so no stray read follows
			n_reg <= (n_next == 256) ? 0 : n_next;
			data_rd <= drq && !stall && n_next < 256;
		end
	end
endmodule

// >>> verif/idd_gen_tb.sv
// Self-checking bench for the identify-data generator
`timescale 1ns/1ps
module idd_gen_tb;
	import idd_pkg::*;
	localparam int D = 4;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic true_ide = 1'b0;
	logic [2:0] capacity_sel = 3'h0;
	idd_ident_t ident = '0;
	logic go = 1'b0;
	logic stall = 1'b0;
	logic identify_start;
	logic data_rd;
	logic drq;
	logic busy;
	logic [15:0] data_out;
	logic [31:0] seed = 32'hadd3_be12;
	logic [15:0] exp_q[$];
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	int lat = -1;
	string nm[8] = '{"256MB", "512MB", "1GB", "2GB", "4GB", "8GB", "256MB", "256MB"};
	logic [15:0] cyl_t[8] = '{16'h03D4, 16'h03E1, 16'h07C2, 16'h0F82, 16'h1F04, 16'h3E08,
		16'h03D4, 16'h03D4};

	always #10 clock = ~clock;

	idd_gen #(.DRQ_DELAY_CYC(D), .DRQ_MAX_CYC(20)) DUT (.clock(clock), .resetn(resetn),
		.true_ide(true_ide), .capacity_sel(capacity_sel), .ident(ident),
		.identify_start(identify_start), .data_rd(data_rd), .drq(drq), .busy(busy),
		.data_out(data_out));
	idd_host host (.clock(clock), .resetn(resetn), .go(go), .stall(stall), .drq(drq),
		.identify_start(identify_start), .data_rd(data_rd));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [15:0] exp_word(int i, logic [2:0] c, logic ide, idd_ident_t id);
		logic [15:0] cyl;
		logic [15:0] spt;
		logic [31:0] lba;
		logic [319:0] mdl;
		string s;
		cyl = cyl_t[c];
		spt = (c inside {[1:5]}) ? 16'h003F : 16'h0020;
		lba = cyl * 16 * spt;
		s = {nm[c], " PCMCIA card"};
		for (int k = 0; k < 40; k++) mdl[319 - 8 * k -: 8] = (k < s.len()) ? s[k] : 8'h20;
		if (id.model_override) mdl = id.model;
		case (i) inside
			0: return ide ? 16'h044A : 16'h848A;
			1, 54: return cyl;
			3, 55: return 16'h0010;
			5: return 16'h0240;
			6, 56: return spt;
			7, 58, 61: return lba[31:16];
			8, 57, 60: return lba[15:0];
			[10:19]: return id.serial[159 - 16 * (i - 10) -: 16];
			20, 21: return 16'h0002;
			22: return 16'h0004;
			[23:26]: return id.firmware[63 - 16 * (i - 23) -: 16];
			[27:46]: return mdl[319 - 16 * (i - 27) -: 16];
			47: return 16'h0001;
			49: return 16'h0300;
			51: return 16'h0203;
			53, 64: return 16'h0003;
			59: return 16'h0100;
			63: return 16'h0407;
			[65:68]: return 16'h0078;
			default: return 16'h0000;
		endcase
	endfunction

	task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic test_done();
		$display("Counts: %0d mismatches, %0d comparisons", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Random host stalls
	always @(posedge clock) stall <= (rnd() % 4) == 0;

	// Output watcher
	always @(posedge clock) begin
		cycles++;
		if (cycles > 10000) begin
			n_fail++;
			test_done();
		end
		if (resetn && identify_start && busy === 1'b0 && drq === 1'b0) lat = 0;
		else if (lat >= 0) lat++;
		if (lat > 0) check("busy level", 32'(lat <= D), busy);
		if (lat > 0 && drq === 1'b1) begin
			check("drq latency", D + 1, lat);
			lat = -1;
		end
		if (drq === 1'b1 && data_rd === 1'b1) check("identify word", exp_q.pop_front(), data_out);
	end

	initial begin
		logic [575:0] v;
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		// Every capacity code, both modes, default and custom model
		for (int r = 0; r < 8; r++) begin
			@(posedge clock);
			for (int k = 0; k < 18; k++) v[32 * k +: 32] = rnd();
			v[0] = r[2] & r[1];
			capacity_sel <= r[2:0];
			true_ide <= r[0];
			ident <= v[544:0];
			for (int i = 0; i < 256; i++) exp_q.push_back(exp_word(i, r[2:0], r[0], v[544:0]));
			go <= 1'b1;
			@(posedge clock);
			go <= 1'b0;
			repeat (3) @(posedge clock);
			// Second command while busy must be ignored
			go <= 1'b1;
			@(posedge clock);
			go <= 1'b0;
			while (exp_q.size() > 0) @(posedge clock);
			repeat (3) @(posedge clock);
		end
		test_done();
	end
endmodule
